// [src/rpsq_map.vh]
// Constants for the reset pin sequencer
`ifndef RPSQ_MAP_VH
`define RPSQ_MAP_VH
`define RPSQ_DRIVE_CYCLES   512
`define RPSQ_RELEASE_CYCLES 10
`define RPSQ_LOCK_EXTRA     512
`define RPSQ_MRST_MIN       4
`define RPSQ_TSC_CYCLES     10
`define RPSQ_FIRST_BUS      10
`define RPSQ_CNT_W          10
`define RPSQ_NUM_CS         11
`define RPSQ_CS_RESET       11'h7ff
`define RPSQ_CS_RUN         11'h7fe
`define RPSQ_ST_POWERON     3'h0
`define RPSQ_ST_IDLE        3'h1
`define RPSQ_ST_WAITEXT     3'h2
`define RPSQ_ST_DRIVE       3'h3
`define RPSQ_ST_RELEASE     3'h4
`define RPSQ_ST_BOOTWAIT    3'h5
`endif

// [src/rpsq_tsc_filter.v]
// Three-state control qualifier: input must stay high for a set number of cycles
`timescale 1ns/1ns
`include "rpsq_map.vh"
module rpsq_tsc_filter #(
    parameter HOLD = `RPSQ_TSC_CYCLES
) (
    input  wire clk,
    input  wire reset_n,
    input  wire ce,
    input  wire tsc_in,
    output reg  tsc_latched_r
);
    reg [3:0] cnt_r;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r         <= 4'h0;
            tsc_latched_r <= 1'b0;
        end else if (ce) begin
            if (!tsc_in)
                cnt_r <= 4'h0;
            else if (cnt_r != HOLD[3:0])
                cnt_r <= cnt_r + 4'h1;
            // Sticky until power-down: drivers cannot be trusted to return
            if (tsc_in && cnt_r == HOLD[3:0] - 4'h1)
                tsc_latched_r <= 1'b1;
        end
    end
endmodule // rpsq_tsc_filter

// [src/rpsq_main.v]
// Reset pin sequencer: drives the reset pin and system pin states around reset
// Summary of operation
// - External request may wait for the current bus cycle to end.
// - After external release, pin stays driven low 512 more cycles.
// - Internal reset drives pin at least 512 cycles, longer while asserted.
// - After each drive period, pin released ten cycles then sampled.
// - Sample high starts reset processing; low repeats another 512-cycle period.
// - In reset, system pins float or sit inactive, never active.
// - In reset chip selects high, bus lines float; after, boot select low.
// - Strobes and read/write drive only after release; acks stay inputs.
// - Data, clock mode and three-state pins are latched as modes at release.
// - General-purpose port pins go high impedance after reset.
// - Power-on holds both resets until clock lock plus 512 cycles.
// - Power-on timing holds its count at zero until clock lock.
// - Other modules reset after master reset held four cycles.
// - Three-state control held ten cycles floats every output driver.
// - External clock mode: float after about ten clock pulses.
// - After three-state takes effect, only power cycle restores operation.
// - First bus cycle starts ten cycles after reset pin release.
// - Reset requests are taken only at the end of a bus cycle.
// - Reset status bits update when the reset pin is released.
`timescale 1ns/1ns
`include "rpsq_map.vh"
module rpsq_main #(
    parameter CNT_W = `RPSQ_CNT_W,
    parameter DATA_W = 16
) (
    input  wire              CORE_CLK,
    input  wire              RESET_N,
    input  wire              CLK_EN,
    input  wire              RESET_PIN_IN,
    output reg               RESET_PIN_OUT,
    output reg               RESET_PIN_OE,
    input  wire              INT_RESET_REQ,
    input  wire              PLL_LOCKED,
    input  wire              BUS_CYCLE_END,
    input  wire              THREE_STATE_CONTROL,
    input  wire              CLOCK_MODE_SELECT,
    input  wire [DATA_W-1:0] DATA_IN,
    output reg               MASTER_RESET_INTERNAL,
    output reg               MODULE_RESET,
    output reg  [10:0]       CS_OUT_N,
    output reg  [10:0]       CS_OE,
    output reg               BUS_OUT_OE,
    output reg               STROBE_OE,
    output reg               PORT_OE,
    output reg               ALL_OUTPUTS_OFF,
    output reg               FIRST_BUS_GO,
    output reg  [DATA_W-1:0] MODE_DATA,
    output reg               MODE_CLOCK_SYNTH,
    output reg               MODE_TSC,
    output reg  [2:0]        RESET_STATUS
);
    // ----------------------------------------------------------------
    // State and counters
    // ----------------------------------------------------------------
    reg [2:0]       state_r;
    reg [2:0]       state_nxt;
    reg [CNT_W-1:0] cnt_r;
    reg [CNT_W-1:0] cnt_nxt;
    reg             pin_s1_r;
    reg             pin_s2_r;
    reg             src_ext_r;
    reg             src_int_r;
    reg             src_por_r;
    reg [2:0]       mrst_cnt_r;
    reg [3:0]       bus_cnt_r;
    reg             bus_wait_r;
    wire            tsc_latched;

    rpsq_tsc_filter #(
        .HOLD (`RPSQ_TSC_CYCLES)
    ) u_tsc (
        .clk           (CORE_CLK),
        .reset_n       (RESET_N),
        .ce            (CLK_EN),
        .tsc_in        (THREE_STATE_CONTROL),
        .tsc_latched_r (tsc_latched)
    );

    // ----------------------------------------------------------------
    // Pin synchroniser
    // ----------------------------------------------------------------
    // Pin is sampled every cycle; ext_low ignores it while we drive it, so our own drive never looks external
    always @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pin_s1_r <= 1'b1;
            pin_s2_r <= 1'b1;
        end else if (CLK_EN) begin
            pin_s1_r <= RESET_PIN_IN;
            pin_s2_r <= pin_s1_r;
        end
    end

    wire ext_low = !pin_s2_r && !RESET_PIN_OE;
    // Requests wait for a bus cycle boundary so writes finish cleanly
    wire req_ok  = BUS_CYCLE_END;
    // Pin is checked one cycle before the window ends, so the decision lands on it
    wire rel_end = cnt_r == `RPSQ_RELEASE_CYCLES - 1;
    wire drv_end = cnt_r == `RPSQ_DRIVE_CYCLES - 1;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always @* begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r + 1'b1;
        case (state_r)
            `RPSQ_ST_POWERON: begin
                // Counting waits for clock lock; the count stays at zero before it
                if (!PLL_LOCKED)
                    cnt_nxt = {CNT_W{1'b0}};
                else if (drv_end) begin
                    state_nxt = `RPSQ_ST_RELEASE;
                    cnt_nxt   = {CNT_W{1'b0}};
                end
            end
            `RPSQ_ST_IDLE: begin
                cnt_nxt = {CNT_W{1'b0}};
                if (req_ok && INT_RESET_REQ)
                    state_nxt = `RPSQ_ST_DRIVE;
                else if (req_ok && ext_low)
                    state_nxt = `RPSQ_ST_WAITEXT;
            end
            `RPSQ_ST_WAITEXT: begin
                cnt_nxt = {CNT_W{1'b0}};
                if (!ext_low)
                    state_nxt = `RPSQ_ST_DRIVE;
            end
            `RPSQ_ST_DRIVE: begin
                if (drv_end && !INT_RESET_REQ) begin
                    state_nxt = `RPSQ_ST_RELEASE;
                    cnt_nxt   = {CNT_W{1'b0}};
                end else if (drv_end)
                    cnt_nxt = cnt_r;
            end
            `RPSQ_ST_RELEASE: begin
                if (rel_end) begin
                    cnt_nxt = {CNT_W{1'b0}};
                    if (pin_s2_r)
                        state_nxt = `RPSQ_ST_BOOTWAIT;
                    else
                        state_nxt = `RPSQ_ST_DRIVE;
                end
            end
            `RPSQ_ST_BOOTWAIT: begin
                cnt_nxt = {CNT_W{1'b0}};
                state_nxt = `RPSQ_ST_IDLE;
            end
            default: begin
                state_nxt = `RPSQ_ST_POWERON;
                cnt_nxt   = {CNT_W{1'b0}};
            end
        endcase
    end

    wire in_reset_nxt = state_nxt != `RPSQ_ST_IDLE && state_nxt != `RPSQ_ST_BOOTWAIT;
    wire release_evt  = state_r == `RPSQ_ST_RELEASE && state_nxt == `RPSQ_ST_BOOTWAIT;

    always @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_r    <= `RPSQ_ST_POWERON;
            cnt_r      <= {CNT_W{1'b0}};
            src_ext_r  <= 1'b0;
            src_int_r  <= 1'b0;
            src_por_r  <= 1'b1;
            mrst_cnt_r <= 3'h0;
            bus_cnt_r  <= 4'h0;
            bus_wait_r <= 1'b0;
        end else if (CLK_EN) begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            if (state_r == `RPSQ_ST_IDLE && state_nxt == `RPSQ_ST_WAITEXT)
                src_ext_r <= 1'b1;
            else if (state_r == `RPSQ_ST_IDLE && state_nxt == `RPSQ_ST_DRIVE)
                src_int_r <= 1'b1;
            else if (release_evt) begin
                src_ext_r <= 1'b0;
                src_int_r <= 1'b0;
                src_por_r <= 1'b0;
            end
            if (MASTER_RESET_INTERNAL && mrst_cnt_r != `RPSQ_MRST_MIN)
                mrst_cnt_r <= mrst_cnt_r + 3'h1;
            else if (!MASTER_RESET_INTERNAL)
                mrst_cnt_r <= 3'h0;
            if (release_evt) begin
                bus_wait_r <= 1'b1;
                bus_cnt_r  <= 4'h0;
            end else if (bus_wait_r) begin
                bus_cnt_r <= bus_cnt_r + 4'h1;
                if (bus_cnt_r == `RPSQ_FIRST_BUS - 2)
                    bus_wait_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    always @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RESET_PIN_OUT         <= 1'b0;
            RESET_PIN_OE          <= 1'b1;
            MASTER_RESET_INTERNAL <= 1'b1;
            MODULE_RESET          <= 1'b0;
            CS_OUT_N              <= `RPSQ_CS_RESET;
            CS_OE                 <= 11'h7ff;
            BUS_OUT_OE            <= 1'b0;
            STROBE_OE             <= 1'b0;
            PORT_OE               <= 1'b0;
            ALL_OUTPUTS_OFF       <= 1'b0;
            FIRST_BUS_GO          <= 1'b0;
            MODE_DATA             <= {DATA_W{1'b0}};
            MODE_CLOCK_SYNTH      <= 1'b1;
            MODE_TSC              <= 1'b0;
            RESET_STATUS          <= 3'h0;
        end else if (CLK_EN) begin
            RESET_PIN_OUT <= 1'b0;
            RESET_PIN_OE  <= in_reset_nxt && state_nxt != `RPSQ_ST_RELEASE
                             && state_nxt != `RPSQ_ST_WAITEXT && !tsc_latched;
            MASTER_RESET_INTERNAL <= in_reset_nxt;
            MODULE_RESET  <= mrst_cnt_r >= `RPSQ_MRST_MIN - 1 && MASTER_RESET_INTERNAL;
            CS_OUT_N      <= in_reset_nxt ? `RPSQ_CS_RESET : `RPSQ_CS_RUN;
            CS_OE         <= tsc_latched ? 11'h000 : 11'h7ff;
            BUS_OUT_OE    <= !in_reset_nxt && !tsc_latched;
            STROBE_OE     <= !in_reset_nxt && !tsc_latched;
            PORT_OE       <= 1'b0;
            ALL_OUTPUTS_OFF <= tsc_latched;
            FIRST_BUS_GO  <= bus_wait_r && bus_cnt_r == `RPSQ_FIRST_BUS - 2;
            if (release_evt) begin
                MODE_DATA        <= DATA_IN;
                MODE_CLOCK_SYNTH <= CLOCK_MODE_SELECT;
                MODE_TSC         <= THREE_STATE_CONTROL;
                RESET_STATUS     <= {src_por_r, src_int_r, src_ext_r};
            end
        end
    end
endmodule // rpsq_main

// [testbench/rpsq_sva.sv]
// Port assertions for the reset pin sequencer
`timescale 1ns/1ns
module rpsq_sva (
    input wire        CORE_CLK,
    input wire        RESET_N,
    input wire        RESET_PIN_IN,
    input wire        RESET_PIN_OE,
    input wire        THREE_STATE_CONTROL,
    input wire        MASTER_RESET_INTERNAL,
    input wire        MODULE_RESET,
    input wire [10:0] CS_OUT_N,
    input wire [10:0] CS_OE,
    input wire        BUS_OUT_OE,
    input wire        STROBE_OE,
    input wire        PORT_OE,
    input wire        ALL_OUTPUTS_OFF,
    input wire        FIRST_BUS_GO
);
    int drv_cnt;
    always @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) drv_cnt <= 0;
        else drv_cnt <= RESET_PIN_OE ? drv_cnt + 1 : 0;
    end
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);
    AST_DRIVE_MIN: assert property ($fell(RESET_PIN_OE) |-> drv_cnt >= 512)
        else $error("drive period under 512 cycles");
    AST_FLOAT_WIN: assert property ($fell(RESET_PIN_OE) |-> !RESET_PIN_OE [*8])
        else $error("release window too short");
    AST_SAMPLE: assert property ($fell(RESET_PIN_OE) |-> ##[9:12] (RESET_PIN_OE || !MASTER_RESET_INTERNAL))
        else $error("no outcome after release window");
    AST_NEG_HIGH: assert property ($fell(MASTER_RESET_INTERNAL) |-> !RESET_PIN_OE && RESET_PIN_IN)
        else $error("master reset negated with pin low or driven");
    AST_IN_RESET: assert property (MASTER_RESET_INTERNAL |-> CS_OUT_N == 11'h7ff && !STROBE_OE && !BUS_OUT_OE)
        else $error("pin active during reset");
    AST_BOOT_CS: assert property ($fell(MASTER_RESET_INTERNAL) |-> ##[0:1] CS_OUT_N == 11'h7fe)
        else $error("boot select not active after release");
    AST_PORT_FLOAT: assert property (!PORT_OE)
        else $error("port pins driven");
    AST_MOD_RESET: assert property ($rose(MODULE_RESET) |-> $past(MASTER_RESET_INTERNAL, 3))
        else $error("module reset before four master reset cycles");
    AST_FIRST_BUS: assert property ($fell(MASTER_RESET_INTERNAL) |-> ##[8:12] FIRST_BUS_GO)
        else $error("first bus cycle mistimed");
    AST_TSC_FLOAT: assert property (ALL_OUTPUTS_OFF |-> !BUS_OUT_OE && !STROBE_OE && CS_OE == 11'h000)
        else $error("driver on while three-stated");
    AST_TSC_STICKY: assert property (ALL_OUTPUTS_OFF |=> ALL_OUTPUTS_OFF)
        else $error("three-state left without power cycle");
    COV_RELEASE: cover property ($fell(MASTER_RESET_INTERNAL));
    COV_REDRIVE: cover property ($fell(RESET_PIN_OE) ##10 RESET_PIN_OE);
    COV_TSC: cover property ($rose(ALL_OUTPUTS_OFF));
endmodule // rpsq_sva
bind rpsq_main rpsq_sva u_sva (.*);

// [testbench/rpsq_ext_model.sv]
// External reset circuitry on the open-drain reset pin
`timescale 1ns/1ns
module rpsq_ext_model (
    input  wire       clk,
    input  wire       hold_req,
    input  wire [7:0] stretch,
    input  wire       dev_oe,
    output reg        pull_low
);
    reg       armed = 1'b0;
    reg       oe_q = 1'b0;
    reg [7:0] left = 8'h00;
    initial pull_low = 1'b0;
    // Grabs the pin once inside the first float window, forcing a second period
    always @(posedge clk) begin
        oe_q <= dev_oe;
        if (oe_q && !dev_oe && armed && !hold_req) begin
            left <= stretch;
            armed <= 1'b0;
        end else if (hold_req) armed <= 1'b1;
        else if (left != 8'h00) left <= left - 8'h01;
        pull_low <= hold_req || left > 8'h01;
    end
endmodule // rpsq_ext_model

// [testbench/tb_top.sv]
// Self-checking bench for the reset pin sequencer
`timescale 1ns/1ns
module tb_top;
    reg         clk = 1'b0, rst_n = 1'b0, int_req = 1'b0, pll = 1'b0, bce = 1'b0, tsc = 1'b0;
    reg         cms = 1'b0, hold = 1'b0, oe_q = 1'b1, go_seen = 1'b0;
    reg  [15:0] din = 16'h0000;
    reg  [7:0]  stretch = 8'h00;
    wire        pin_out, pin_oe, ext_low, mrst, mod_rst, bus_oe, strb_oe, port_oe, off, go, mode_cs, mode_tsc;
    wire [10:0] cs_n, cs_oe;
    wire [15:0] mode_d;
    wire [2:0]  status;
    wire        pin = ~((pin_oe & ~pin_out) | ext_low);
    int         failures = 0, comparisons = 0, periods, hi, seed, k;
    always #4 clk = ~clk;
    rpsq_main u_dut (.CORE_CLK(clk), .RESET_N(rst_n), .CLK_EN(1'b1), .RESET_PIN_IN(pin), .RESET_PIN_OUT(pin_out),
        .RESET_PIN_OE(pin_oe), .INT_RESET_REQ(int_req), .PLL_LOCKED(pll), .BUS_CYCLE_END(bce),
        .THREE_STATE_CONTROL(tsc), .CLOCK_MODE_SELECT(cms), .DATA_IN(din), .MASTER_RESET_INTERNAL(mrst),
        .MODULE_RESET(mod_rst), .CS_OUT_N(cs_n), .CS_OE(cs_oe), .BUS_OUT_OE(bus_oe), .STROBE_OE(strb_oe),
        .PORT_OE(port_oe), .ALL_OUTPUTS_OFF(off), .FIRST_BUS_GO(go), .MODE_DATA(mode_d),
        .MODE_CLOCK_SYNTH(mode_cs), .MODE_TSC(mode_tsc), .RESET_STATUS(status));
    rpsq_ext_model u_ext (.clk(clk), .hold_req(hold), .stretch(stretch), .dev_oe(pin_oe), .pull_low(ext_low));
    always @(posedge clk) begin
        if (pin_oe === 1'b1 && oe_q !== 1'b1) periods++;
        if (pin_oe === 1'b1) hi++;
        if (go === 1'b1) go_seen = 1'b1;
        oe_q = pin_oe;
    end
    task tally_and_finish;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input string what, input [31:0] exp, input [31:0] got);
        comparisons++;
        if (exp !== got) begin
            failures++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task wait_mrst(input bit lvl, input int lim);
        int n;
        for (n = 0; n < lim && mrst !== lvl; n++) @(posedge clk) #1;
        if (mrst !== lvl) begin
            chk("wait for master reset", lvl, mrst);
            tally_and_finish;
        end
    endtask
    // ----------------------------------------
    // Model: drive time is the longer of 512 and the internal hold, plus 512 per extra period
    // ----------------------------------------
    task chk_rel(input [2:0] st, input int p, input int held);
        int e;
        e = (held > 512 ? held : 512) + 512 * (p - 1);
        @(posedge clk) #1;
        chk("status", st, status);
        chk("chip selects", 11'h7fe, cs_n);
        chk("strobes on", 2'h3, {strb_oe, bus_oe});
        chk("mode data", {tsc, cms, din}, {mode_tsc, mode_cs, mode_d});
        chk("pin out level", 0, pin_out);
        if (p > 0) chk("periods", p, periods);
        if (p > 0) chk("drive window", 1, hi >= e && hi <= e + 4);
        repeat (12) @(posedge clk);
        chk("first bus", 1, go_seen);
    endtask
    initial begin
        seed = 44785;
        din = $random(seed);
        cms = $random(seed);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3 + $unsigned($random(seed)) % 20) @(posedge clk);
        pll <= 1'b1;
        wait_mrst(1'b0, 2000);
        chk_rel(3'h4, 0, 0);
        for (k = 0; k < 4; k++) begin
            @(posedge clk);
            din <= $random(seed);
            periods = 0;
            hi = 0;
            go_seen = 1'b0;
            if (k < 2) begin
                int_req <= 1'b1;
                repeat (5) @(posedge clk) #1;
                chk("held off mid cycle", 0, pin_oe | mrst);
                bce <= 1'b1;
                @(posedge clk);
                bce <= 1'b0;
                repeat (k * 699) @(posedge clk);
                int_req <= 1'b0;
            end else begin
                bce <= 1'b1;
                hold <= 1'b1;
                stretch <= (k == 3) ? 8'h0f : 8'h00;
                repeat (30 + $unsigned($random(seed)) % 40) @(posedge clk);
                hold <= 1'b0;
            end
            wait_mrst(1'b1, 100);
            wait_mrst(1'b0, 3000);
            bce <= 1'b0;
            chk_rel(k < 2 ? 3'h2 : 3'h1, k == 3 ? 2 : 1, k == 1 ? 700 : 0);
        end
        tsc <= 1'b1;
        repeat (3) @(posedge clk) #1;
        chk("early float", 0, off);
        repeat (12) @(posedge clk);
        tsc <= 1'b0;
        repeat (20) @(posedge clk) #1;
        chk("outputs floated", 23'h400000, {off, bus_oe, strb_oe, cs_oe, port_oe, 8'h00});
        tally_and_finish;
    end
endmodule // tb_top
